// file: src/apo_alarm_protection_output.sv
// Alarm supervision, short-circuit sequencer and protection output
`timescale 1ns/1ns
`default_nettype none
module apo_alarm_protection_output
   import apo_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset,
   // Register port
   input  wire logic        regWr,
   input  wire logic        regRd,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWdata,
   output logic      [15:0] regRdata,
   // Measurement inputs from regulation logic, same clock
   input  wire logic [15:0] voltage,
   input  wire logic [15:0] ovTemplate,
   input  wire logic [15:0] uvTemplate,
   input  wire logic [15:0] freqHz,
   input  wire logic [15:0] uspeedThresh,
   input  wire logic [15:0] ospeedThresh,
   input  wire logic [15:0] excCurrent,
   input  wire logic [15:0] excCurrentThresh,
   input  wire logic [15:0] observer,
   input  wire logic [15:0] observerUpper,
   input  wire logic [15:0] observerLower,
   input  wire logic        shortDetect,
   input  wire logic [7:0]  scTolerance,
   input  wire logic        transient,
   input  wire logic        excOverVoltage,
   input  wire logic        polarityFlag,
   input  wire logic        fwRevAtLeast18,
   // Pins
   input  wire logic        supplyOkPin,
   input  wire logic        rotorStoppedPin,
   // Outputs
   output logic             protection_output,
   output logic [15:0]      alarmFlags,
   output logic             storeAlarm,
   output logic [15:0]      alarm_snapshot_record,
   output logic [31:0]      elapsed_time_record,
   output logic             haltState,
   output logic             excitationEnable,
   output logic             currentLimitActive,
   output logic             vfRampEnable
);
   // ----------------------------------------
   // Pin synchronisers and tick
   // ----------------------------------------
   logic [1:0] pinSync;
   logic       tick;
   apo_sync2 #(.W(2)) uSync (
      .clk   (clk),
      .reset (reset),
      .din   ({supplyOkPin, rotorStoppedPin}),
      .dout  (pinSync)
   );
   apo_tick_div #(.CYCLES(TICK_CYC)) uTick (
      .clk   (clk),
      .reset (reset),
      .tick  (tick)
   );
   wire supplyOk     = pinSync[1];
   wire rotorStopped = pinSync[0];

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   logic [15:0]   select_r;
   logic [15:0]   flags_r;
   logic [15:0]   stored_r;
   logic [7:0]    ovInhibit_r;
   logic [7:0]    scCount_r;
   logic [3:0]    secTick_r;
   logic [3:0]    delayCnt_r;
   logic          delayDone_r;
   logic          lowFreqOff_r;
   logic [31:0]   runTicks_r;
   apo_sc_state_t scState_r;
   apo_sc_state_t scState_nxt;

   // ----------------------------------------
   // Alarm conditions
   // ----------------------------------------
   wire belowStop  = freqHz < 16'(STOP_FREQ_HZ);
   wire uspeedCond = freqHz < uspeedThresh;
   wire ospeedCond = freqHz > ospeedThresh;
   wire ovCond     = (voltage > ovTemplate) && (ovInhibit_r == 8'h0);
   wire uvCond     = (voltage < uvTemplate) && !uspeedCond
                     && !transient && !excOverVoltage;
   wire scCond     = shortDetect && !belowStop;
   wire ocCond     = excCurrent > excCurrentThresh;
   wire uexcCond   = ((observer > observerUpper) || (observer < observerLower))
                     && !transient;

   // Per-alarm live vector at weight positions
   logic [15:0] live;
   always_comb begin
      live              = 16'h0;
      live[BIT_OVERV]   = ovCond;
      live[BIT_UNDERV]  = uvCond;
      live[BIT_SHORT]   = scCond;
      live[BIT_OVEREXC] = ocCond;
      live[BIT_USPEED]  = uspeedCond;
      live[BIT_OSPEED]  = ospeedCond;
      live[BIT_UEXC]    = uexcCond;
      live[BIT_HEALTHY] = (live[BIT_UEXC:BIT_OVERV] == 7'h0);
   end

   // Alarms written to the record store; underspeed is not one of them
   wire [15:0] storeMask = 16'h00de;
   wire [15:0] newStore  = live & storeMask & ~stored_r;
   wire [7:0]  enableBits = select_r[7:0] & {BIT_UEXC+1{1'b1}} & 8'hfe;
   wire        anyEnabled = |(live[7:0] & enableBits);
   wire [3:0]  delaySec   = select_r[15:DELAY_LSB];
   wire        invertOn   = polarityFlag && fwRevAtLeast18;

   // ----------------------------------------
   // Short-circuit sequencer
   // ----------------------------------------
   always_comb begin
      scState_nxt = scState_r;
      case (scState_r)
         SC_IDLE: begin
            if (scCond && scTolerance != 8'h0) scState_nxt = SC_TIME;
         end
         SC_TIME: begin
            if (!scCond) scState_nxt = SC_IDLE;
            else if (scCount_r >= scTolerance) scState_nxt = SC_SAVE;
         end
         SC_SAVE: scState_nxt = SC_HALT;
         SC_HALT: begin
            if (belowStop) scState_nxt = SC_IDLE;
         end
         default: scState_nxt = SC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scState_r <= SC_IDLE;
         scCount_r <= 8'h0;
      end else begin
         scState_r <= scState_nxt;
         if (scState_r != SC_TIME) scCount_r <= 8'h0;
         else if (tick && scCount_r != 8'hff) scCount_r <= scCount_r + 8'h1;
      end
   end

   // ----------------------------------------
   // Over-voltage inhibit after transitions
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) ovInhibit_r <= 8'(OV_INHIBIT_TICKS);
      else if (transient) ovInhibit_r <= 8'(OV_INHIBIT_TICKS);
      else if (tick && ovInhibit_r != 8'h0) ovInhibit_r <= ovInhibit_r - 8'h1;
   end

   // ----------------------------------------
   // Low-frequency shutdown latch
   // ----------------------------------------
   // Once off we stay off; only a full stop re-arms the regulator
   always_ff @(posedge clk) begin
      if (reset) lowFreqOff_r <= 1'b0;
      else if (belowStop) lowFreqOff_r <= 1'b1;
      else if (rotorStopped) lowFreqOff_r <= 1'b0;
   end

   // ----------------------------------------
   // Flags, record store and timers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         flags_r               <= 16'h0;
         stored_r              <= 16'h0;
         storeAlarm            <= 1'b0;
         alarm_snapshot_record <= 16'h0;
         elapsed_time_record   <= 32'h0;
         runTicks_r            <= 32'h0;
      end else begin
         flags_r    <= live;
         storeAlarm <= (newStore != 16'h0) || (scState_r == SC_SAVE);
         stored_r   <= (stored_r | (live & storeMask)) & live;
         if (tick) runTicks_r <= runTicks_r + 32'h1;
         if ((newStore != 16'h0) || (scState_r == SC_SAVE)) begin
            alarm_snapshot_record <= live;
            elapsed_time_record   <= runTicks_r;
         end
      end
   end

   // ----------------------------------------
   // Output delay in whole seconds
   // ----------------------------------------
   // Restarts whenever the enabled set becomes non-empty
   always_ff @(posedge clk) begin
      if (reset) begin
         secTick_r   <= 4'h0;
         delayCnt_r  <= 4'h0;
         delayDone_r <= 1'b0;
      end else if (!anyEnabled) begin
         secTick_r   <= 4'h0;
         delayCnt_r  <= 4'h0;
         delayDone_r <= 1'b0;
      end else if (!delayDone_r) begin
         if (delayCnt_r >= delaySec) delayDone_r <= 1'b1;
         else if (tick) begin
            if (secTick_r == 4'(TICKS_PER_SEC - 1)) begin
               secTick_r  <= 4'h0;
               delayCnt_r <= delayCnt_r + 4'h1;
            end else secTick_r <= secTick_r + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   wire selWr = regWr && (regAddr == ADDR_SELECT);
   always_ff @(posedge clk) begin
      if (reset) select_r <= SELECT_RESET;
      else if (selWr) select_r <= regWdata;
   end

   wire [15:0] rdMux = (regAddr == ADDR_SELECT)   ? select_r :
                       (regAddr == ADDR_OBSERVER) ? observer :
                       (regAddr == ADDR_FLAGS)    ? flags_r  : 16'h0;

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Unpowered: polarity set means open (0); polarity clear also open
   always_ff @(posedge clk) begin
      if (reset) begin
         regRdata           <= 16'h0;
         protection_output  <= 1'b0;
         alarmFlags         <= 16'h0;
         haltState          <= 1'b0;
         excitationEnable   <= 1'b0;
         currentLimitActive <= 1'b0;
         vfRampEnable       <= 1'b0;
      end else begin
         regRdata   <= regRd ? rdMux : 16'h0;
         alarmFlags <= flags_r;
         if (!supplyOk) protection_output <= 1'b0;
         else if (invertOn) protection_output <= !delayDone_r;
         else protection_output <= delayDone_r;
         haltState          <= (scState_r == SC_HALT);
         excitationEnable   <= (scState_r != SC_HALT) && !lowFreqOff_r;
         currentLimitActive <= ocCond;
         vfRampEnable       <= uspeedCond;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_ZERO_TOL_NO_HALT: assert property (@(posedge clk) disable iff (reset)
      (scState_r == SC_IDLE && scTolerance == 8'h0) |=> scState_r != SC_TIME)
      else $error("short-circuit timing started with zero tolerance");
   AST_HALT_CUTS_EXC: assert property (@(posedge clk) disable iff (reset)
      (scState_r == SC_HALT) |=> !excitationEnable && haltState)
      else $error("halt did not cut excitation");
   AST_SAVE_BEFORE_HALT: assert property (@(posedge clk) disable iff (reset)
      (scState_r == SC_SAVE) |=> storeAlarm && scState_r == SC_HALT)
      else $error("halt entered without record save");
   AST_SC_LOWFREQ: assert property (@(posedge clk) disable iff (reset)
      belowStop |-> !live[BIT_SHORT])
      else $error("short circuit flagged below stop frequency");
   AST_UV_GATED: assert property (@(posedge clk) disable iff (reset)
      (uspeedCond || transient || excOverVoltage) |-> !live[BIT_UNDERV])
      else $error("under-voltage flagged while inhibited");
   AST_HEALTHY: assert property (@(posedge clk) disable iff (reset)
      !$past(reset) |-> flags_r[BIT_HEALTHY] == (flags_r[7:1] == 7'h0))
      else $error("healthy bit inconsistent with alarms");
   AST_MASKED_NORMAL: assert property (@(posedge clk) disable iff (reset)
      (!anyEnabled && supplyOk) ##1 (!anyEnabled && supplyOk) |=>
      protection_output == $past(invertOn))
      else $error("output left normal state with no enabled alarm");
   AST_LOWFREQ_OFF: assert property (@(posedge clk) disable iff (reset)
      belowStop |=> ##1 !excitationEnable)
      else $error("excitation kept below stop frequency");
   AST_RAMP: assert property (@(posedge clk) disable iff (reset)
      uspeedCond |=> vfRampEnable)
      else $error("ramp not enabled in underspeed");
   AST_NO_DELAY: assert property (@(posedge clk) disable iff (reset)
      ($rose(anyEnabled) && delaySec == 4'h0 && supplyOk) ##1 (anyEnabled && supplyOk) |=>
      protection_output == !invertOn)
      else $error("zero delay output not asserted");
endmodule
`default_nettype wire

// file: src/apo_pkg.sv
// Package: shared constants for the alarm and protection-output block
package apo_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0]  ADDR_SELECT      = 8'h11;
   localparam logic [7:0]  ADDR_OBSERVER    = 8'h38;
   localparam logic [7:0]  ADDR_FLAGS       = 8'h26;
   localparam logic [15:0] SELECT_RESET     = 16'h0000;
   // ----------------------------------------
   // Field positions in the selection and flag words
   // ----------------------------------------
   localparam int DELAY_LSB   = 12;
   localparam int BIT_OVERV   = 1;
   localparam int BIT_UNDERV  = 2;
   localparam int BIT_SHORT   = 3;
   localparam int BIT_OVEREXC = 4;
   localparam int BIT_USPEED  = 5;
   localparam int BIT_OSPEED  = 6;
   localparam int BIT_UEXC    = 7;
   localparam int BIT_HEALTHY = 11;
   localparam int NUM_ALARMS  = 7;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ          = 100_000_000;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_SEC   = 10;
   localparam int OV_INHIBIT_S    = 2;
   localparam int OV_INHIBIT_TICKS = OV_INHIBIT_S * TICKS_PER_SEC;
   localparam int STOP_FREQ_HZ    = 20;
   // ----------------------------------------
   // Short-circuit sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SC_IDLE = 2'b00,
      SC_TIME = 2'b01,
      SC_SAVE = 2'b10,
      SC_HALT = 2'b11
   } apo_sc_state_t;
endpackage

// file: src/apo_tick_div.sv
// Divider producing a one-cycle enable every tick period
`timescale 1ns/1ns
`default_nettype none
module apo_tick_div
   import apo_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic reset,
   output logic      tick
);
   logic [31:0] cnt_r;
   // --------------------------------------
   // Free-running count, pulse on wrap
   // --------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= 32'h0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_r == 32'(CYCLES - 1));
         cnt_r <= (cnt_r == 32'(CYCLES - 1)) ? 32'h0 : cnt_r + 32'h1;
      end
   end
endmodule
`default_nettype wire

// file: src/apo_sync2.sv
// Two-flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ns
`default_nettype none
module apo_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;
   // --------------------------------------
   // First stage is read only by the second
   // --------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: dv/apo_far_side.sv
// Far-side model: regulator supply, alternator rotor and excitation field
`timescale 1ns/1ns
`default_nettype none
module apo_far_side #(
   parameter int SPIN_DOWN = 20
) (
   input  wire logic clk,
   input  wire logic powerOn,
   input  wire logic spinning,
   input  wire logic excitationEnable,
   output logic      supplyOkPin,
   output logic      rotorStoppedPin,
   output logic      fieldLive
);
   int coast = 0;
   // ----------------------------------------
   // Rotor
   // ----------------------------------------
   // A rotor coasts down; standstill is reported only once it has run out
   always_ff @(posedge clk) begin
      if (spinning) begin
         coast <= SPIN_DOWN;
      end else if (coast > 0) begin
         coast <= coast - 1;
      end
   end
   assign rotorStoppedPin = !spinning && coast == 0;
   // Supply pin simply follows the bench's power switch
   assign supplyOkPin = powerOn;
   // Field carries current only while driven and powered
   assign fieldLive = excitationEnable && powerOn;
endmodule
`default_nettype wire

// file: dv/tb_apo_alarm_protection_output.sv
// Self-checking testbench for the alarm and protection-output block
`timescale 1ns/1ns
`default_nettype none
module tb_apo_alarm_protection_output
   import apo_pkg::*;
;
   logic        clk = 0, reset = 1, regWr = 0, regRd = 0, shortDetect = 0, transient = 0;
   logic        excOverVoltage = 0, polarityFlag = 0, fwRevAtLeast18 = 1, powerOn = 1, spinning = 1;
   logic [7:0]  regAddr = 8'h00, scTolerance = 8'h00;
   logic [15:0] regWdata = 16'h0000, voltage = 16'h03e8, ovTemplate = 16'h07d0, uvTemplate = 16'h01f4;
   logic [15:0] freqHz = 16'h0032, uspeedThresh = 16'h0028, ospeedThresh = 16'h003c;
   logic [15:0] excCurrent = 16'h000a, excCurrentThresh = 16'h0064, observer = 16'h0064;
   logic [15:0] observerUpper = 16'h00c8, observerLower = 16'h0032;
   logic [15:0] regRdata, alarmFlags, alarm_snapshot_record, w;
   logic [31:0] elapsed_time_record, t0;
   logic        protection_output, storeAlarm, haltState, excitationEnable, currentLimitActive;
   logic        vfRampEnable, supplyOkPin, rotorStoppedPin, fieldLive, rdPend = 0;
   logic [15:0] rdQ[$];
   int          n_fail = 0, tests_run = 0, seedv, nStore = 0, n0;

   apo_alarm_protection_output #(.TICK_CYC(10)) DUT (
      .clk, .reset, .regWr, .regRd, .regAddr, .regWdata, .regRdata, .voltage, .ovTemplate,
      .uvTemplate, .freqHz, .uspeedThresh, .ospeedThresh, .excCurrent, .excCurrentThresh,
      .observer, .observerUpper, .observerLower, .shortDetect, .scTolerance, .transient,
      .excOverVoltage, .polarityFlag, .fwRevAtLeast18, .supplyOkPin, .rotorStoppedPin,
      .protection_output, .alarmFlags, .storeAlarm, .alarm_snapshot_record,
      .elapsed_time_record, .haltState, .excitationEnable, .currentLimitActive, .vfRampEnable);
   apo_far_side FAR (.clk, .powerOn, .spinning, .excitationEnable, .supplyOkPin,
      .rotorStoppedPin, .fieldLive);

   always #5 clk = ~clk;

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic end_sim;
      $display("compares %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input int sel);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: output %0d is %b expected %b", $time, sel, got, exp);
      end
   endtask

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      step(1);
      regWr = 1;
      regAddr = a;
      regWdata = d;
      step(1);
      regWr = 0;
   endtask
   // Note the expected word; the monitor compares it when the answer lands
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      step(1);
      regRd = 1;
      regAddr = a;
      rdQ.push_back(e);
      step(1);
      regRd = 0;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return protection_output;
         1: return haltState;
         2: return excitationEnable;
         3: return vfRampEnable;
         4: return currentLimitActive;
         default: return fieldLive;
      endcase
   endfunction
   // Wait (hold=0) or hold (hold=1) a level for up to lim cycles, then compare once
   task automatic expect_bit(input int sel, input logic exp, input int lim, input bit hold);
      logic v;
      for (int i = 0; i < lim; i++) begin
         step(1);
         v = pick(sel);
         if (hold ? (v !== exp) : (v === exp)) break;
      end
      chk_bit(v, exp, sel);
   endtask

   // Read answers come one cycle after the read edge
   always @(posedge clk) begin
      if (rdPend) begin
         chk_word(regRdata, rdQ.pop_front());
      end
      // Each record-store pulse lasts one cycle, so it is counted once
      if (storeAlarm) nStore++;
      rdPend <= regRd;
   end

   // Watchdog, far beyond the several hundred cycles the tests need
   initial begin
      #300000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_sim();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      seedv = $urandom(43);
      step(12);
      reset = 0;
      step(5);
      rd(ADDR_FLAGS, 16'h0800);
      rd(ADDR_SELECT, SELECT_RESET);
      rd(8'h12, 16'h0000);
      expect_bit(2, 1'b1, 5, 0);
      expect_bit(0, 1'b0, 5, 1);
      // Selection word readback, then a random enable set; observer is read-only
      wr(ADDR_SELECT, 16'h5042);
      rd(ADDR_SELECT, 16'h5042);
      w = {4'h3, 4'h0, 7'($urandom % 128), 1'b0};
      wr(ADDR_SELECT, w);
      rd(ADDR_SELECT, w);
      wr(ADDR_OBSERVER, 16'h1234);
      rd(ADDR_OBSERVER, 16'h0064);
      // Under-voltage with zero delay closes, then releases when gone
      wr(ADDR_SELECT, 16'h0004);
      n0 = nStore;
      voltage = 16'h0100 + 16'($urandom % 240);
      step(4);
      rd(ADDR_FLAGS, 16'h0004);
      chk_word(alarmFlags, 16'h0004);
      chk_word(alarm_snapshot_record, 16'h0004);
      chk_bit(nStore == n0 + 1, 1'b1, 8);
      t0 = elapsed_time_record;
      expect_bit(0, 1'b1, 6, 0);
      voltage = 16'h03e8;
      expect_bit(0, 1'b0, 6, 0);
      // Same alarm masked out leaves the output alone
      wr(ADDR_SELECT, 16'h0002);
      voltage = 16'h0100;
      expect_bit(0, 1'b0, 30, 1);
      voltage = 16'h03e8;
      // One-second delay is 100 cycles at a 10-cycle tick
      wr(ADDR_SELECT, 16'h1004);
      voltage = 16'h0100;
      expect_bit(0, 1'b0, 80, 1);
      expect_bit(0, 1'b1, 40, 0);
      voltage = 16'h03e8;
      expect_bit(0, 1'b0, 6, 0);
      // Transient and underspeed both hold the under-voltage off
      wr(ADDR_SELECT, 16'h0004);
      transient = 1;
      voltage = 16'h0100;
      expect_bit(0, 1'b0, 30, 1);
      transient = 0;
      expect_bit(0, 1'b1, 6, 0);
      freqHz = 16'h001e;
      n0 = nStore;
      expect_bit(3, 1'b1, 6, 0);
      expect_bit(0, 1'b0, 6, 0);
      rd(ADDR_FLAGS, 16'h0020);
      chk_bit(nStore == n0, 1'b1, 8);
      freqHz = 16'h0032;
      voltage = 16'h03e8;
      // Underexcitation, overspeed, overcurrent
      observer = 16'h0010;
      step(4);
      rd(ADDR_FLAGS, 16'h0080);
      observer = 16'h0064;
      freqHz = 16'h0046;
      step(4);
      rd(ADDR_FLAGS, 16'h0040);
      expect_bit(2, 1'b1, 4, 1);
      freqHz = 16'h0032;
      excCurrent = 16'h00c8;
      expect_bit(4, 1'b1, 6, 0);
      excCurrent = 16'h000a;
      step(6);
      // Polarity: closed normally when set, open when supply lost or old firmware
      polarityFlag = 1;
      expect_bit(0, 1'b1, 6, 0);
      powerOn = 0;
      expect_bit(0, 1'b0, 5, 0);
      powerOn = 1;
      fwRevAtLeast18 = 0;
      expect_bit(0, 1'b0, 8, 1);
      fwRevAtLeast18 = 1;
      polarityFlag = 0;
      // Over-voltage stays quiet for two seconds (200 cycles) after a transient
      transient = 1;
      step(1);
      transient = 0;
      voltage = 16'h0900;
      step(150);
      rd(ADDR_FLAGS, 16'h0800);
      step(60);
      rd(ADDR_FLAGS, 16'h0002);
      voltage = 16'h03e8;
      step(4);
      // Short circuit: zero tolerance never blocks, three ticks does
      shortDetect = 1;
      step(4);
      rd(ADDR_FLAGS, 16'h0008);
      expect_bit(1, 1'b0, 60, 1);
      scTolerance = 8'h03;
      expect_bit(1, 1'b1, 60, 0);
      chk_word(alarm_snapshot_record, 16'h0008);
      chk_bit(elapsed_time_record > t0, 1'b1, 7);
      expect_bit(5, 1'b0, 3, 0);
      shortDetect = 0;
      freqHz = 16'h000a;
      expect_bit(1, 1'b0, 6, 0);
      expect_bit(2, 1'b0, 15, 1);
      spinning = 0;
      step(30);
      freqHz = 16'h0032;
      step(5);
      spinning = 1;
      expect_bit(2, 1'b1, 10, 0);
      step(3);
      end_sim();
   end
endmodule
`default_nettype wire
